// [logic/mmar_mode_result.sv]
// Mode control, measurement sequencing and axis result registers
`timescale 1ns/100ps
`default_nettype none
// Summary of operation
// - Mode register reads 0x01 after reset: single measurement.
// - Mode bit 7 enables high-speed serial bus mode.
// - Mode bit 5 forces slowest output rate and single-sample averaging.
// - Mode bit 4 is stored but changes nothing.
// - Mode bit 2 picks three-wire (1) or four-wire (0) serial wiring.
// - Mode field: 00 continuous, 01 single, 10 and 11 idle.
// - Idle mode takes no measurements until another mode is written.
// - Continuous mode repeats measurements, sets ready after all three axes.
// - After restart, first set after two periods, then one per period.
// - Single mode: one measurement, ready raised, then idle.
// - Finished single measurement rewrites mode field to idle.
// - Result and ready stay until results read or new measurement.
// - Each axis holds 16-bit signed result, high byte then low byte.
// - Overflowed axis conversion loads marker value -4096.
// - Marker is replaced by the next valid measurement.
// - Serial bytes travel most significant bit first.
// - A result read blocks updates from the next cycle on, until all six read or mode/config written.
// - Continuous rate comes from a three-bit configuration field.
// - Mode read or partial result read locks; mode/config write unlocks.
module mmar_mode_result #(
    parameter logic [7:0][23:0] PERIOD_CYC = mmar_pkg::PERIOD_CYC_DEF
) (
    input  wire logic                   clk_sys,
    input  wire logic                   rst_n,
    input  wire logic                   ce,
    input  wire logic                   linkClk,
    input  wire logic                   linkSelN,
    input  wire logic                   linkSdi,
    output logic                        linkSdo,
    output logic                        linkSdoOe,
    output logic                        convStart,
    output logic [1:0]                  convAvg,
    output logic [1:0]                  convBias,
    input  wire logic                   convDone,
    input  wire mmar_pkg::mmar_sample_t convData,
    output logic                        i2cHighSpeedEnable,
    output logic                        spiWireCountSelect,
    output logic                        dataReadyPin
);
    typedef struct packed {
        logic                 reqMeta;
        logic                 reqSync;
        logic                 reqSeen;
        logic                 ackTog;
        logic [7:0]           rdData;
        logic [7:0]           modeReg;
        logic [7:0]           cfgReg;
        logic [2:0][15:0]     res;
        logic [5:0]           readMask;
        logic                 locked;
        logic                 ready;
        mmar_pkg::mmar_meas_t fsm;
        logic [23:0]          periodCnt;
        logic                 warm;
        logic                 convStart;
        logic [1:0]           convAvg;
    } mmar_sys_st_t;

    mmar_sys_st_t        st_reg;
    mmar_sys_st_t        st_next;
    mmar_pkg::mmar_req_t linkReq;
    logic                linkReqTog;
    logic                reqEvt;
    logic                restart;
    logic                tick;
    logic                doPlace;
    logic [2:0]          byteIdx;
    logic [2:0]          rateIdx;
    logic [7:0]          readVal;
    logic [5:0]          newMask;
    logic [2:0][15:0]    placeVal;

    mmar_link_port u_link (
        .linkClk   (linkClk),
        .rst_n     (rst_n),
        .linkSelN  (linkSelN),
        .linkSdi   (linkSdi),
        .linkSdo   (linkSdo),
        .linkSdoOe (linkSdoOe),
        .req       (linkReq),
        .reqTog    (linkReqTog),
        .ackTog    (st_reg.ackTog),
        .rdData    (st_reg.rdData)
    );

    for (genvar i = 0; i < 3; i++) begin : g_axis
        assign placeVal[i] = convData.ovf[i] ? mmar_pkg::OVF_VAL
                                             : convData.axis[i];
    end

    always_comb begin
        st_next = st_reg;
        restart = 1'b0;
        doPlace = 1'b0;
        readVal = 8'h00;
        newMask = st_reg.readMask;
        byteIdx = 3'(linkReq.addr - mmar_pkg::ADDR_XH);
        rateIdx = st_reg.modeReg[mmar_pkg::MODE_LP_BIT] ? mmar_pkg::RATE_LP
                                                        : st_reg.cfgReg[4:2];
        st_next.convAvg = st_reg.modeReg[mmar_pkg::MODE_LP_BIT]
                          ? mmar_pkg::AVG_ONE : st_reg.cfgReg[6:5];
        st_next.reqMeta = linkReqTog;
        st_next.reqSync = st_reg.reqMeta;
        st_next.reqSeen = st_reg.reqSync;
        reqEvt = st_reg.reqSync != st_reg.reqSeen;
        st_next.convStart = 1'b0;

        tick = st_reg.periodCnt <= mmar_pkg::CNT_ONE;
        if (st_reg.fsm == mmar_pkg::MS_IDLE) begin
            st_next.periodCnt = PERIOD_CYC[rateIdx];
            st_next.warm = 1'b1;
        end else if (tick) begin
            st_next.periodCnt = PERIOD_CYC[rateIdx];
            st_next.warm = 1'b0;
        end else begin
            st_next.periodCnt = st_reg.periodCnt - mmar_pkg::CNT_ONE;
        end

        case (st_reg.fsm)
            mmar_pkg::MS_IDLE: begin
                if (st_reg.modeReg[1:0] == mmar_pkg::MD_SINGLE) begin
                    st_next.convStart = 1'b1;
                    st_next.fsm = mmar_pkg::MS_CONV;
                end else if (st_reg.modeReg[1:0] == mmar_pkg::MD_CONT) begin
                    st_next.fsm = mmar_pkg::MS_COUNT;
                end
            end
            mmar_pkg::MS_COUNT: begin
                if (st_reg.modeReg[1:0] != mmar_pkg::MD_CONT) begin
                    st_next.fsm = mmar_pkg::MS_IDLE;
                end else if (tick && !st_reg.warm) begin
                    st_next.convStart = 1'b1;
                    st_next.fsm = mmar_pkg::MS_CONV;
                end
            end
            mmar_pkg::MS_CONV: begin
                if (convDone) begin
                    doPlace = 1'b1;
                    st_next.fsm = mmar_pkg::MS_COUNT;
                    if (st_reg.modeReg[1:0] == mmar_pkg::MD_SINGLE) begin
                        st_next.modeReg[1:0] = mmar_pkg::MD_IDLE;
                        st_next.fsm = mmar_pkg::MS_IDLE;
                    end
                end
            end
            default: st_next.fsm = mmar_pkg::MS_IDLE;
        endcase

        case (linkReq.addr)
            mmar_pkg::ADDR_CFG: readVal = st_reg.cfgReg;
            mmar_pkg::ADDR_MODE: readVal = st_reg.modeReg;
            default: begin
                readVal = byteIdx[0] ? st_reg.res[byteIdx[2:1]][7:0]
                                     : st_reg.res[byteIdx[2:1]][15:8];
            end
        endcase

        if (reqEvt) begin
            st_next.ackTog = ~st_reg.ackTog;
            if (linkReq.read) begin
                st_next.rdData = readVal;
                if (linkReq.addr == mmar_pkg::ADDR_MODE) begin
                    st_next.locked = 1'b1;
                end else if (linkReq.addr != mmar_pkg::ADDR_CFG) begin
                    newMask = st_reg.readMask
                              | (mmar_pkg::ONE_BYTE << byteIdx);
                    st_next.locked = 1'b1;
                    if (newMask == mmar_pkg::ALL_READ) begin
                        newMask = '0;
                        st_next.locked = 1'b0;
                        st_next.ready = 1'b0;
                    end
                    st_next.readMask = newMask;
                end
            end else if (linkReq.addr == mmar_pkg::ADDR_MODE
                         || linkReq.addr == mmar_pkg::ADDR_CFG) begin
                if (linkReq.addr == mmar_pkg::ADDR_MODE) begin
                    st_next.modeReg = linkReq.data;
                end else begin
                    st_next.cfgReg = linkReq.data;
                end
                restart = 1'b1;
                st_next.locked = 1'b0;
                st_next.readMask = '0;
                st_next.fsm = mmar_pkg::MS_IDLE;
                st_next.convStart = 1'b0;
            end
        end

        // data and ready held
        // Placement after read handling so a new set wins the clear
        if (doPlace && !restart && (!st_reg.locked || !st_next.locked)) begin
            st_next.res = placeVal;
            st_next.ready = 1'b1;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            st_reg <= '0;
            st_reg.modeReg <= mmar_pkg::MODE_RST;
            st_reg.cfgReg <= mmar_pkg::CFG_RST;
        end else if (ce) begin
            st_reg <= st_next;
        end
    end

    assign convStart          = st_reg.convStart;
    assign convAvg            = st_reg.convAvg;
    assign convBias           = st_reg.cfgReg[1:0];
    assign i2cHighSpeedEnable = st_reg.modeReg[mmar_pkg::MODE_HS_BIT];
    assign spiWireCountSelect = st_reg.modeReg[mmar_pkg::MODE_SPI3_BIT];
    assign dataReadyPin       = st_reg.ready;

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    logic placing;
    logic rdEvt;
    logic wrReq;
    logic wrMode;
    logic resRd;
    logic lastRd;
    assign placing = ce && doPlace && !restart
                     && (!st_reg.locked || !st_next.locked);
    assign rdEvt   = ce && reqEvt && linkReq.read;
    assign wrReq   = ce && reqEvt && !linkReq.read
                     && (linkReq.addr == mmar_pkg::ADDR_MODE
                         || linkReq.addr == mmar_pkg::ADDR_CFG);
    assign wrMode  = wrReq && linkReq.addr == mmar_pkg::ADDR_MODE;
    assign resRd   = rdEvt && linkReq.addr != mmar_pkg::ADDR_MODE
                     && linkReq.addr != mmar_pkg::ADDR_CFG;
    assign lastRd  = resRd && (st_reg.readMask
                     | (mmar_pkg::ONE_BYTE << byteIdx)) == mmar_pkg::ALL_READ;

    AST_RESET_MODE: assert property (
        $rose(rst_n) |-> st_reg.modeReg == mmar_pkg::MODE_RST)
        else $error("mode register not at reset value");
    AST_RESET_RES: assert property (
        $rose(rst_n) |-> st_reg.res == '0 && !dataReadyPin)
        else $error("results not zero after reset");
    AST_IDLE_QUIET: assert property (
        ce && st_reg.fsm == mmar_pkg::MS_IDLE && st_reg.modeReg[1]
        |=> !convStart)
        else $error("conversion started in idle mode");
    AST_SINGLE_IDLE: assert property (
        ce && st_reg.fsm == mmar_pkg::MS_CONV && convDone && !reqEvt
        && st_reg.modeReg[1:0] == mmar_pkg::MD_SINGLE
        |=> st_reg.modeReg[1:0] == mmar_pkg::MD_IDLE
        && st_reg.fsm == mmar_pkg::MS_IDLE)
        else $error("single measurement did not return to idle");
    AST_PLACE_READY: assert property (
        placing |=> dataReadyPin && st_reg.res == $past(placeVal))
        else $error("results not placed with ready");
    AST_OVF_MARK: assert property (
        placing && convData.ovf[0] |=> st_reg.res[0] == mmar_pkg::OVF_VAL)
        else $error("overflow marker missing");
    AST_LOCK_HOLD: assert property (
        st_reg.locked && st_next.locked |=> $stable(st_reg.res))
        else $error("locked results changed");
    AST_READY_HOLD: assert property (
        dataReadyPin && !rdEvt |=> dataReadyPin)
        else $error("ready dropped without a read");
    AST_LP_AVG: assert property (
        ce && st_reg.modeReg[mmar_pkg::MODE_LP_BIT]
        |=> convAvg == mmar_pkg::AVG_ONE)
        else $error("averaging not forced in lowest power");
    AST_WARM_SKIP: assert property (
        ce && st_reg.fsm == mmar_pkg::MS_COUNT && st_reg.warm
        |=> !convStart)
        else $error("conversion in first output period");
    AST_MODE_LOCK: assert property (
        rdEvt && linkReq.addr == mmar_pkg::ADDR_MODE |=> st_reg.locked)
        else $error("mode read did not lock");
    AST_MODE_STORE: assert property (
        wrMode |=> st_reg.modeReg == $past(linkReq.data))
        else $error("mode write not stored as written");
    AST_HS_WRITE: assert property (
        wrMode |=> i2cHighSpeedEnable
                   == $past(linkReq.data[mmar_pkg::MODE_HS_BIT]))
        else $error("high-speed enable does not follow mode write");
    AST_WIRE_WRITE: assert property (
        wrMode |=> spiWireCountSelect
                   == $past(linkReq.data[mmar_pkg::MODE_SPI3_BIT]))
        else $error("wire count select does not follow mode write");
    AST_WRITE_UNLOCK: assert property (
        wrReq |=> !st_reg.locked && st_reg.readMask == '0
                  && st_reg.fsm == mmar_pkg::MS_IDLE)
        else $error("register write did not unlock and restart");
    AST_PART_LOCK: assert property (
        resRd && !lastRd |=> st_reg.locked)
        else $error("partial result read did not lock");
    AST_LAST_READ: assert property (
        lastRd && !placing |=> !dataReadyPin && !st_reg.locked)
        else $error("sixth result read did not release");
    AST_SINGLE_GO: assert property (
        ce && !reqEvt && st_reg.fsm == mmar_pkg::MS_IDLE
        && st_reg.modeReg[1:0] == mmar_pkg::MD_SINGLE |=> convStart)
        else $error("single mode did not start a conversion");
    AST_ONE_PULSE: assert property (
        ce && convStart |=> !convStart)
        else $error("conversion start longer than one cycle");
    AST_CONT_GO: assert property (
        ce && !reqEvt && st_reg.fsm == mmar_pkg::MS_COUNT && tick
        && !st_reg.warm && st_reg.modeReg[1:0] == mmar_pkg::MD_CONT
        |=> convStart)
        else $error("continuous mode missed a period");
    AST_RATE_LOAD: assert property (
        ce && st_reg.fsm == mmar_pkg::MS_IDLE
        && !st_reg.modeReg[mmar_pkg::MODE_LP_BIT]
        |=> st_reg.periodCnt == PERIOD_CYC[$past(st_reg.cfgReg[4:2])])
        else $error("period not taken from rate field");

    COV_SINGLE: cover property (
        placing && st_reg.modeReg[1:0] == mmar_pkg::MD_SINGLE);
    COV_CONT: cover property (
        placing && st_reg.modeReg[1:0] == mmar_pkg::MD_CONT);
    COV_LOCK_DROP: cover property (
        ce && doPlace && st_reg.locked);
    COV_OVF: cover property (placing && convData.ovf != '0);
endmodule : mmar_mode_result
`default_nettype wire

// [logic/mmar_pkg.sv]
// Shared constants and carrier types for the mode and result block
package mmar_pkg;
    localparam logic [63:0] CLK_HZ     = 64'h0098_9680;
    localparam logic [63:0] MHZ_PER_HZ = 64'h0000_03e8;
    // Output rates in millihertz, by rate code
    localparam logic [63:0] RATE_MHZ [8] = '{
        64'h2ee, 64'h5dc, 64'hbb8, 64'h1d4c,
        64'h3a98, 64'h7530, 64'h124f8, 64'h35b60
    };

    function automatic logic [23:0] periodCyc(input logic [63:0] mhz);
        return 24'((CLK_HZ * MHZ_PER_HZ) / mhz);
    endfunction : periodCyc

    localparam logic [7:0][23:0] PERIOD_CYC_DEF = {
        periodCyc(RATE_MHZ[7]), periodCyc(RATE_MHZ[6]),
        periodCyc(RATE_MHZ[5]), periodCyc(RATE_MHZ[4]),
        periodCyc(RATE_MHZ[3]), periodCyc(RATE_MHZ[2]),
        periodCyc(RATE_MHZ[1]), periodCyc(RATE_MHZ[0])
    };
    localparam logic [23:0] CNT_ONE = 24'h000001;

    localparam logic [2:0] ADDR_CFG  = 3'h0;
    localparam logic [2:0] ADDR_MODE = 3'h1;
    localparam logic [2:0] ADDR_XH   = 3'h2;

    localparam int MODE_HS_BIT   = 7;
    localparam int MODE_LP_BIT   = 5;
    localparam int MODE_SPI3_BIT = 2;
    localparam logic [1:0] MD_CONT   = 2'h0;
    localparam logic [1:0] MD_SINGLE = 2'h1;
    localparam logic [1:0] MD_IDLE   = 2'h2;
    localparam logic [7:0] MODE_RST  = 8'h01;
    localparam logic [7:0] CFG_RST   = 8'h10;
    localparam logic [2:0] RATE_LP   = 3'h0;
    localparam logic [1:0] AVG_ONE   = 2'h0;

    localparam logic [15:0] OVF_VAL  = 16'hf000;
    localparam logic [5:0]  ALL_READ = 6'h3f;
    localparam logic [5:0]  ONE_BYTE = 6'h01;

    localparam int         CMD_READ_BIT = 7;
    localparam logic [6:0] BYTE_LAST    = 7'h07;
    localparam logic [6:0] WAIT_LAST    = 7'h2f;

    typedef enum logic [1:0] {
        MS_IDLE  = 2'b00,
        MS_COUNT = 2'b01,
        MS_CONV  = 2'b10
    } mmar_meas_t;

    typedef enum logic [2:0] {
        FR_CMD   = 3'b000,
        FR_WDATA = 3'b001,
        FR_WAIT  = 3'b010,
        FR_RDATA = 3'b011,
        FR_DONE  = 3'b100
    } mmar_frame_t;

    typedef struct packed {
        logic [2:0][15:0] axis;
        logic [2:0]       ovf;
    } mmar_sample_t;

    typedef struct packed {
        logic       read;
        logic [2:0] addr;
        logic [7:0] data;
    } mmar_req_t;
endpackage : mmar_pkg

// [logic/mmar_link_port.sv]
// Serial link front end clocked by the host's link clock
`timescale 1ns/100ps
`default_nettype none
module mmar_link_port (
    input  wire logic          linkClk,
    input  wire logic          rst_n,
    input  wire logic          linkSelN,
    input  wire logic          linkSdi,
    output logic               linkSdo,
    output logic               linkSdoOe,
    output mmar_pkg::mmar_req_t req,
    output logic               reqTog,
    input  wire logic          ackTog,
    input  wire logic [7:0]    rdData
);
    typedef struct packed {
        logic                  rstMeta;
        logic                  rstSync;
        logic                  ackMeta;
        logic                  ackSync;
        mmar_pkg::mmar_frame_t phase;
        logic [6:0]            bitCnt;
        logic [7:0]            shIn;
        logic [7:0]            shOut;
        logic                  oe;
        logic [2:0]            cmdAddr;
        logic                  reqTog;
        mmar_pkg::mmar_req_t   req;
    } mmar_link_st_t;

    mmar_link_st_t st_reg;
    mmar_link_st_t st_next;
    logic          busy;
    logic [7:0]    inByte;

    always_comb begin
        st_next = st_reg;
        st_next.rstMeta = rst_n;
        st_next.rstSync = st_reg.rstMeta;
        st_next.ackMeta = ackTog;
        st_next.ackSync = st_reg.ackMeta;
        // Request fields stay frozen until the system side answers
        busy = st_reg.reqTog != st_reg.ackSync;
        inByte = {st_reg.shIn[6:0], linkSdi};
        if (!st_reg.rstSync) begin
            st_next.phase = mmar_pkg::FR_CMD;
            st_next.bitCnt = '0;
            st_next.oe = 1'b0;
            st_next.shOut = '0;
            st_next.reqTog = 1'b0;
            st_next.req = '0;
        end else if (linkSelN) begin
            st_next.phase = mmar_pkg::FR_CMD;
            st_next.bitCnt = '0;
            st_next.oe = 1'b0;
        end else begin
            st_next.bitCnt = st_reg.bitCnt + 7'h01;
            st_next.shIn = inByte;
            case (st_reg.phase)
                mmar_pkg::FR_CMD: begin
                    if (st_reg.bitCnt == mmar_pkg::BYTE_LAST) begin
                        st_next.bitCnt = '0;
                        st_next.cmdAddr = inByte[2:0];
                        if (inByte[mmar_pkg::CMD_READ_BIT]) begin
                            st_next.phase = mmar_pkg::FR_WAIT;
                            if (!busy) begin
                                st_next.req.read = 1'b1;
                                st_next.req.addr = inByte[2:0];
                                st_next.reqTog = ~st_reg.reqTog;
                            end
                        end else begin
                            st_next.phase = mmar_pkg::FR_WDATA;
                        end
                    end
                end
                mmar_pkg::FR_WDATA: begin
                    if (st_reg.bitCnt == mmar_pkg::BYTE_LAST) begin
                        st_next.phase = mmar_pkg::FR_DONE;
                        if (!busy) begin
                            st_next.req.read = 1'b0;
                            st_next.req.addr = st_reg.cmdAddr;
                            st_next.req.data = inByte;
                            st_next.reqTog = ~st_reg.reqTog;
                        end
                    end
                end
                mmar_pkg::FR_WAIT: begin
                    // Unanswered read shifts out zero rather than stale data
                    if (st_reg.bitCnt == mmar_pkg::WAIT_LAST) begin
                        st_next.shOut = busy ? 8'h00 : rdData;
                        st_next.oe = 1'b1;
                        st_next.bitCnt = '0;
                        st_next.phase = mmar_pkg::FR_RDATA;
                    end
                end
                mmar_pkg::FR_RDATA: begin
                    st_next.shOut = {st_reg.shOut[6:0], 1'b0};
                    if (st_reg.bitCnt == mmar_pkg::BYTE_LAST) begin
                        st_next.oe = 1'b0;
                        st_next.phase = mmar_pkg::FR_DONE;
                    end
                end
                mmar_pkg::FR_DONE: begin
                    // Clock stops between frames: this edge opens a command
                    st_next.phase = mmar_pkg::FR_CMD;
                    st_next.bitCnt = 7'h01;
                end
                default: st_next.bitCnt = st_reg.bitCnt;
            endcase
        end
    end

    always_ff @(posedge linkClk) begin
        st_reg <= st_next;
    end

    assign linkSdo   = st_reg.shOut[7];
    assign linkSdoOe = st_reg.oe;
    assign req       = st_reg.req;
    assign reqTog    = st_reg.reqTog;
endmodule : mmar_link_port
`default_nettype wire

// [sim/mmar_host_model.sv]
// Host side of the serial link; its clock runs inside frames and during reset pulses
`timescale 1ns/100ps
`default_nettype none
module mmar_host_model (
    output logic      linkClk,
    output logic      linkSelN,
    output logic      linkSdi,
    input  wire logic linkSdo,
    input  wire logic linkSdoOe
);
    initial begin
        linkClk = 1'b0;
        linkSelN = 1'b1;
        linkSdi = 1'b0;
    end
    // Link state clears only on link edges while reset is held
    task automatic pulseReset;
        repeat (4) begin
            #7.5 linkClk = 1'b1;
            #7.5 linkClk = 1'b0;
        end
    endtask : pulseReset
    task automatic xfer(input logic rd, input logic [2:0] a,
                        input logic [7:0] wd, output logic [7:0] rdv,
                        output logic oeOk);
        logic [15:0] bits;
        bits = {rd, 4'h0, a, (a == mmar_pkg::ADDR_MODE) ? wd & 8'hb7 : wd};
        rdv = 8'h00;
        oeOk = 1'b1;
        linkSelN = 1'b0;
        for (int i = 0; i < (rd ? 64 : 16); i++) begin
            linkSdi = (i < 8 || !rd) ? bits[15 - i] : ~linkSdi;
            #7.5 linkClk = 1'b1;
            #7.5 linkClk = 1'b0;
            if (i >= 55 && i <= 62) begin
                rdv[62 - i] = linkSdo;
                oeOk = oeOk & linkSdoOe;
            end
        end
        if (rd)
            oeOk = oeOk & !linkSdoOe;
        linkSelN = 1'b1;
        linkSdi = ~linkSdi;
    endtask : xfer
endmodule : mmar_host_model
`default_nettype wire

// [sim/magnetometer_mode_and_result_regs_tb_top.sv]
// Self-checking bench for the mode and result block
`timescale 1ns/100ps
`default_nettype none
module magnetometer_mode_and_result_regs_tb_top;
    localparam logic [7:0][23:0] PER = {24'h6e, 24'h64, 24'h5a, 24'h50,
                                        24'h46, 24'h3c, 24'h32, 24'h28};
    logic clk_sys, rst_n, ce, linkClk, linkSelN, linkSdi, linkSdo, linkSdoOe;
    logic convStart, convDone, hsEn, spi3, rdy, oeOk;
    logic [1:0] convAvg, convBias;
    logic [7:0] got, wd, cfg;
    mmar_pkg::mmar_sample_t convData, smp;
    int errors, n_tests, cyc, nStart, lastStart, gap, pend, convDly, n0;

    mmar_mode_result #(.PERIOD_CYC(PER)) DUT (.clk_sys(clk_sys),
        .rst_n(rst_n), .ce(ce), .linkClk(linkClk), .linkSelN(linkSelN),
        .linkSdi(linkSdi), .linkSdo(linkSdo), .linkSdoOe(linkSdoOe),
        .convStart(convStart), .convAvg(convAvg), .convBias(convBias),
        .convDone(convDone), .convData(convData),
        .i2cHighSpeedEnable(hsEn), .spiWireCountSelect(spi3),
        .dataReadyPin(rdy));
    mmar_host_model host (.linkClk(linkClk), .linkSelN(linkSelN),
        .linkSdi(linkSdi), .linkSdo(linkSdo), .linkSdoOe(linkSdoOe));

    initial begin
        clk_sys = 1'b0;
        forever #50 clk_sys = ~clk_sys;
    end
    // Front end answers each start after convDly cycles
    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        convDone <= 1'b0;
        if (convStart) begin
            nStart <= nStart + 1;
            gap <= cyc - lastStart;
            lastStart <= cyc;
            pend <= convDly;
        end else if (pend == 1) begin
            convDone <= 1'b1;
            convData <= smp;
            pend <= 0;
        end else if (pend > 1)
            pend <= pend - 1;
        if (cyc == 60000) begin
            errors = errors + 1;
            final_report();
        end
    end

    task automatic check(input logic [31:0] g, input logic [31:0] e);
        n_tests++;
        if (g !== e) begin
            errors++;
            $display("unexpected at %0t: got %h expected %h", $time, g, e);
        end
    endtask : check
    task automatic rdReg(input logic [2:0] a, input logic [7:0] e);
        host.xfer(1'b1, a, 8'h00, got, oeOk);
        check(got, e);
        check(oeOk, 1'b1);
        #1000;
    endtask : rdReg
    task automatic wrReg(input logic [2:0] a, input logic [7:0] d);
        host.xfer(1'b0, a, d, got, oeOk);
        #1000;
    endtask : wrReg
    function automatic logic [15:0] expAxis(input int i);
        return smp.ovf[i] ? 16'hf000 : smp.axis[i];
    endfunction : expAxis
    task automatic readAll;
        for (int i = 0; i < 3; i++) begin
            rdReg(3'(2 + 2 * i), 8'(expAxis(i) >> 8));
            rdReg(3'(3 + 2 * i), 8'(expAxis(i)));
        end
    endtask : readAll
    task automatic final_report;
        $display("errors %0d comparisons %0d", errors, n_tests);
        if (errors == 0 && n_tests > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : final_report

    initial begin
        rst_n = 1'b0;
        ce = 1'b1;
        {errors, n_tests, cyc, nStart, lastStart, gap, pend} = '0;
        convDly = 60;
        convDone = 1'b0;
        convData = '0;
        smp = '0;
        void'($urandom(32'h570a));
        host.pulseReset();
        repeat (6) @(posedge clk_sys);
        rst_n <= 1'b1;
        // Link sees the release only on its own clock edges
        host.pulseReset();
        rdReg(mmar_pkg::ADDR_MODE, mmar_pkg::MODE_RST);
        for (int a = 2; a < 8; a++) rdReg(3'(a), 8'h00);
        check(rdy, 1'b0);
        wd = (8'($urandom) & 8'hb7) | 8'h03;
        n0 = nStart;
        wrReg(mmar_pkg::ADDR_MODE, wd);
        check(hsEn, wd[7]);
        check(spi3, wd[2]);
        rdReg(mmar_pkg::ADDR_MODE, wd);
        repeat (300) @(posedge clk_sys);
        check(nStart, n0);
        for (int t = 0; t < 4; t++) begin
            for (int i = 0; i < 3; i++)
                smp.axis[i] = 16'($signed(12'($urandom)));
            smp.ovf = (t == 0) ? 3'h7 : (t == 1) ? 3'h0 : 3'($urandom);
            convDly = 1 + ($urandom % 20);
            wrReg(mmar_pkg::ADDR_MODE, mmar_pkg::MODE_RST);
            for (int k = 0; k < 500 && rdy !== 1'b1; k++) @(posedge clk_sys);
            check(rdy, 1'b1);
            rdReg(mmar_pkg::ADDR_MODE, 8'h02);
            check(rdy, 1'b1);
            readAll();
            check(rdy, 1'b0);
        end
        convDly = 3;
        for (int c = 0; c < 8; c++) begin
            cfg = {1'b0, 2'($urandom), 3'(c), 2'($urandom)};
            wrReg(mmar_pkg::ADDR_CFG, cfg);
            check(convBias, cfg[1:0]);
            wrReg(mmar_pkg::ADDR_MODE, (c == 7) ? 8'h20 : 8'h00);
            check(convAvg, (c == 7) ? 2'b00 : cfg[6:5]);
            n0 = nStart;
            for (int k = 0; k < 1000 && nStart < n0 + 2; k++)
                @(posedge clk_sys);
            check(gap, (c == 7) ? PER[0] : PER[c]);
            check(rdy, 1'b1);
        end
        final_report();
    end
endmodule : magnetometer_mode_and_result_regs_tb_top
`default_nettype wire
